// File: include/hms_defines.vh
`ifndef HMS_DEFINES_VH
`define HMS_DEFINES_VH

// ****************************************
// widths
// ****************************************
`define HMS_AXIS_W      12
`define HMS_TEMP_W      10

// ****************************************
// timing
// ****************************************
`define HMS_BIAS_NS     1000
`define HMS_OSC_NS      1000
`define HMS_PROBE_NS    2000
`define HMS_CONV_NS     3000
`define HMS_CLK_NS      100

// ****************************************
// channel indices
// ****************************************
`define HMS_CH_X        2'h0
`define HMS_CH_Y        2'h1
`define HMS_CH_Z        2'h2
`define HMS_CH_T        2'h3

// ****************************************
// reset values and counter width
// ****************************************
`define HMS_TEMP_EN_RST 1'h1
`define HMS_CNT_W       8

`endif

// File: rtl/hms_result_mem.v
`include "hms_defines.vh"

module hms_result_mem #(
    parameter WIDTH = `HMS_AXIS_W
) (
    // clock
    input  wire             ref_clk,
    input  wire             clk_en,
    // write side
    input  wire             wr_en,
    input  wire [1:0]       wr_addr,
    input  wire [WIDTH-1:0] wr_data,
    // read side
    input  wire [1:0]       rd_addr,
    output reg  [WIDTH-1:0] rd_data
);

    reg [WIDTH-1:0] mem [0:3];

    always @(posedge ref_clk) begin
        if (clk_en) begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            rd_data <= mem[rd_addr];
        end
    end

endmodule // hms_result_mem

// File: rtl/hms_sequencer.v
// Function
// - the device only answers as a bus slave and never starts a transfer itself.
// - after start-up turns on bias and fast oscillator the device idles in low power and takes config.
// - every reconfiguration starts one measurement cycle by itself.
// - a cycle runs bias, supply check with fast oscillator, probe bias, channel conversions, then back to idle.
// - temperature conversion is optional, on after reset, and follows X, Y and Z in the same cycle.
// - while supply is too low the sequencer holds, then restarts its current function from the start (conversions from probe bias).
// - a supply restart event during a function aborts it and runs it again from its start; conversions rerun from probe bias.
// - cycle completion is signalled by an open-drain low pulse on the shared clock/interrupt pin.
// - axis results are 12 bits and the temperature result is 10 bits.
// - a trigger from the master starts a measurement cycle.
`include "hms_defines.vh"

module hms_sequencer #(
    parameter AXIS_W   = `HMS_AXIS_W,
    parameter TEMP_W   = `HMS_TEMP_W,
    parameter INT_LEN  = 4
) (
    // clock and reset
    input  wire              ref_clk,
    input  wire              rst_n,
    input  wire              clk_en,
    // slave-side requests decoded by the serial interface
    input  wire              cfg_wr,
    input  wire              cfg_temp_en,
    input  wire              trig,
    input  wire              if_reset,
    // supply monitor
    input  wire              supply_ok,
    // analog front end
    output reg               bias_en,
    output reg               fosc_en,
    output reg               probe_en,
    output reg  [1:0]        adc_ch,
    output reg               adc_start,
    input  wire              adc_done,
    input  wire [AXIS_W-1:0] adc_data,
    // result readout
    input  wire [1:0]        rd_ch,
    output wire [AXIS_W-1:0] rd_data,
    // status
    output reg               busy,
    output reg               low_power,
    // shared clock / interrupt pin
    output wire              int_o,
    output wire              int_oe
);

    // ****************************************
    // timing
    // ****************************************
    localparam [31:0]           BIAS_NUM  = (`HMS_BIAS_NS + `HMS_CLK_NS - 1) / `HMS_CLK_NS;
    localparam [31:0]           OSC_NUM   = (`HMS_OSC_NS + `HMS_CLK_NS - 1) / `HMS_CLK_NS;
    localparam [31:0]           PROBE_NUM = (`HMS_PROBE_NS + `HMS_CLK_NS - 1) / `HMS_CLK_NS;
    localparam [`HMS_CNT_W-1:0] BIAS_CYC  = BIAS_NUM[`HMS_CNT_W-1:0];
    localparam [`HMS_CNT_W-1:0] OSC_CYC   = OSC_NUM[`HMS_CNT_W-1:0];
    localparam [`HMS_CNT_W-1:0] PROBE_CYC = PROBE_NUM[`HMS_CNT_W-1:0];

    // ****************************************
    // states
    // ****************************************
    localparam [6:0] S_START = 7'h01;
    localparam [6:0] S_IDLE  = 7'h02;
    localparam [6:0] S_BIAS  = 7'h04;
    localparam [6:0] S_OSC   = 7'h08;
    localparam [6:0] S_PROBE = 7'h10;
    localparam [6:0] S_CONV  = 7'h20;
    localparam [6:0] S_DONE  = 7'h40;

    function is_last;
        input [1:0] ch;
        input       t_en;
        begin
            is_last = t_en ? (ch == `HMS_CH_T) : (ch == `HMS_CH_Z);
        end
    endfunction

    // ****************************************
    // reset and input synchronisers
    // ****************************************
    reg  [1:0] rst_sync;
    wire       rst_ok = rst_sync[1];
    reg  [1:0] sup_sync;
    wire       sup = sup_sync[1];
    reg        sup_prev;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'h1};
        end
    end

    always @(posedge ref_clk or negedge rst_ok) begin
        if (!rst_ok) begin
            sup_sync <= 2'h0;
            sup_prev <= 1'h0;
        end else if (clk_en) begin
            sup_sync <= {sup_sync[0], supply_ok};
            sup_prev <= sup;
        end
    end

    wire sup_drop = sup_prev & ~sup;

    // ****************************************
    // sequencer
    // ****************************************
    reg [6:0]            state;
    reg [`HMS_CNT_W-1:0] cnt;
    reg                  temp_en;
    reg                  pend;
    reg [2:0]            int_cnt;
    reg                  wr_en;
    reg [1:0]            wr_addr;
    reg [AXIS_W-1:0]     wr_data;

    wire req = cfg_wr | trig;

    always @(posedge ref_clk or negedge rst_ok) begin
        if (!rst_ok) begin
            state     <= S_START;
            cnt       <= {`HMS_CNT_W{1'b0}};
            temp_en   <= `HMS_TEMP_EN_RST;
            pend      <= 1'h0;
            bias_en   <= 1'h0;
            fosc_en   <= 1'h0;
            probe_en  <= 1'h0;
            adc_ch    <= `HMS_CH_X;
            adc_start <= 1'h0;
            busy      <= 1'h0;
            low_power <= 1'h0;
            int_cnt   <= 3'h0;
            wr_en     <= 1'h0;
            wr_addr   <= 2'h0;
            wr_data   <= {AXIS_W{1'b0}};
        end else if (clk_en) begin
            adc_start <= 1'h0;
            wr_en     <= 1'h0;
            if (int_cnt != 3'h0) begin
                int_cnt <= int_cnt - 3'h1;
            end
            if (cfg_wr) begin
                temp_en <= cfg_temp_en;
            end
            if (if_reset) begin
                temp_en <= `HMS_TEMP_EN_RST;
            end
            // a request that cannot start now is kept, also while supply is low
            if (req && (state != S_IDLE || !sup || sup_drop)) begin
                pend <= 1'h1;
            end
            if (!sup || sup_drop) begin
                cnt <= {`HMS_CNT_W{1'b0}};
                if (state == S_CONV) begin
                    // rerun from probe bias so a fresh start pulse goes out
                    adc_ch <= `HMS_CH_X;
                    state  <= S_PROBE;
                end
            end else begin
                case (state)
                    S_START: begin
                        bias_en <= 1'h1;
                        fosc_en <= 1'h1;
                        cnt     <= cnt + 1'b1;
                        if (cnt >= BIAS_CYC) begin
                            bias_en   <= 1'h0;
                            fosc_en   <= 1'h0;
                            low_power <= 1'h1;
                            cnt       <= {`HMS_CNT_W{1'b0}};
                            state     <= S_IDLE;
                        end
                    end
                    S_IDLE: begin
                        if (req || pend) begin
                            pend      <= 1'h0;
                            busy      <= 1'h1;
                            low_power <= 1'h0;
                            bias_en   <= 1'h1;
                            state     <= S_BIAS;
                        end
                    end
                    S_BIAS: begin
                        cnt <= cnt + 1'b1;
                        if (cnt >= BIAS_CYC) begin
                            cnt     <= {`HMS_CNT_W{1'b0}};
                            fosc_en <= 1'h1;
                            state   <= S_OSC;
                        end
                    end
                    S_OSC: begin
                        cnt <= cnt + 1'b1;
                        if (cnt >= OSC_CYC) begin
                            cnt      <= {`HMS_CNT_W{1'b0}};
                            probe_en <= 1'h1;
                            state    <= S_PROBE;
                        end
                    end
                    S_PROBE: begin
                        cnt <= cnt + 1'b1;
                        if (cnt >= PROBE_CYC) begin
                            cnt       <= {`HMS_CNT_W{1'b0}};
                            adc_ch    <= `HMS_CH_X;
                            adc_start <= 1'h1;
                            state     <= S_CONV;
                        end
                    end
                    S_CONV: begin
                        if (adc_done) begin
                            wr_en   <= 1'h1;
                            wr_addr <= adc_ch;
                            wr_data <= (adc_ch == `HMS_CH_T) ?
                                       {{(AXIS_W-TEMP_W){1'b0}}, adc_data[TEMP_W-1:0]} : adc_data;
                            if (is_last(adc_ch, temp_en)) begin
                                state <= S_DONE;
                            end else begin
                                adc_ch    <= adc_ch + 2'h1;
                                adc_start <= 1'h1;
                            end
                        end
                    end
                    S_DONE: begin
                        // result write lands on the same edge that the interrupt starts
                        bias_en   <= 1'h0;
                        fosc_en   <= 1'h0;
                        probe_en  <= 1'h0;
                        busy      <= 1'h0;
                        low_power <= 1'h1;
                        int_cnt   <= INT_LEN[2:0];
                        state     <= S_IDLE;
                    end
                    default: begin
                        state <= S_START;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // results and interrupt
    // ****************************************
    hms_result_mem #(
        .WIDTH (AXIS_W)
    ) u_mem (
        .ref_clk (ref_clk),
        .clk_en  (clk_en),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .rd_addr (rd_ch),
        .rd_data (rd_data)
    );

    // open-drain: only ever pulls low; no bus mastering here
    assign int_o  = 1'h0;
    assign int_oe = (int_cnt != 3'h0);

endmodule // hms_sequencer

// File: testbench/hms_adc_model.sv
module hms_adc_model (
    // clock
    input  logic        ref_clk,
    // converter handshake
    input  logic        adc_start,
    input  logic [1:0]  adc_ch,
    input  logic        slow,
    output logic        adc_done,
    output logic [11:0] adc_data
);
    timeunit 1ns;
    timeprecision 1ns;
    int         cnt = 0;
    logic [1:0] ch;
    initial adc_done = 1'b0;
    initial adc_data = 12'h000;
    // data valid only with done, inverted after
    always @(posedge ref_clk) begin
        adc_done <= 1'b0;
        if (adc_done) adc_data <= ~adc_data;
        if (adc_start) begin
            ch <= adc_ch;
            cnt <= slow ? 6 : 1;
        end else if (cnt == 1) begin
            adc_done <= 1'b1;
            adc_data <= {ch, 2'h3, 8'h5A};
            cnt <= 0;
        end else if (cnt > 1) cnt <= cnt - 1;
    end
endmodule // hms_adc_model

// File: testbench/hms_seq_sva.sv
module hms_seq_sva #(
    parameter INT_LEN = 4
) (
    // clock and reset
    input logic       ref_clk,
    input logic       rst_n,
    // clock enable, requests and supply
    input logic       clk_en,
    input logic       cfg_wr,
    input logic       trig,
    input logic       supply_ok,
    // sequencer outputs
    input logic       bias_en,
    input logic       fosc_en,
    input logic       probe_en,
    input logic [1:0] adc_ch,
    input logic       adc_start,
    input logic       busy,
    input logic       low_power,
    input logic       int_o,
    input logic       int_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [1:0] last_ch;
    logic [7:0] int_cnt;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_ch <= 2'h0;
            int_cnt <= 8'h00;
        end else begin
            if (adc_start) last_ch <= adc_ch;
            int_cnt <= int_oe ? int_cnt + 8'h01 : 8'h00;
        end
    end
    sequence s_request;
        clk_en && (cfg_wr || trig) && low_power && !busy && $past(supply_ok, 2) && $past(supply_ok, 3);
    endsequence
    sequence s_supply_low;
        !supply_ok [*4];
    endsequence
    a_start_bias: assert property (s_request |=> busy && bias_en) else $error("cycle not started");
    a_conv_pulse: assert property (adc_start |=> !adc_start) else $error("start pulse too long");
    a_conv_ready: assert property (adc_start |-> bias_en && fosc_en && probe_en) else $error("bias missing");
    a_ch_order: assert property (adc_start && adc_ch != 2'h0 |-> adc_ch == last_ch + 2'h1)
        else $error("channel order wrong");
    a_hold_low: assert property (s_supply_low |-> !adc_start) else $error("conversion on low supply");
    a_int_pin_low: assert property (int_oe |-> !int_o) else $error("pin driven high");
    a_int_at_done: assert property ($fell(busy) |-> int_oe) else $error("no interrupt at end");
    a_int_len: assert property ($fell(int_oe) |-> int_cnt == INT_LEN) else $error("pulse length wrong");
    a_int_idle: assert property (int_oe |-> !busy) else $error("interrupt while busy");
    a_low_power_idle: assert property (low_power |-> !busy && !fosc_en) else $error("low power while busy");
endmodule // hms_seq_sva

bind hms_sequencer hms_seq_sva #(.INT_LEN(INT_LEN)) i_sva (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .cfg_wr(cfg_wr), .trig(trig), .supply_ok(supply_ok), .bias_en(bias_en), .fosc_en(fosc_en),
    .probe_en(probe_en), .adc_ch(adc_ch), .adc_start(adc_start), .busy(busy), .low_power(low_power),
    .int_o(int_o), .int_oe(int_oe));

// File: testbench/hms_sequencer_test.sv
module hms_sequencer_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk, rst_n, clk_en, cfg_wr, cfg_temp_en, trig, if_reset, supply_ok, slow;
    logic        adc_done, adc_start, bias_en, fosc_en, probe_en, busy, low_power, int_o, int_oe;
    logic [1:0]  adc_ch, rd_ch;
    logic [11:0] adc_data, rd_data;
    logic [1:0]  seq[$];
    int          fails, num_checks;

    hms_sequencer #(.INT_LEN(4)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .cfg_wr(cfg_wr),
        .cfg_temp_en(cfg_temp_en), .trig(trig), .if_reset(if_reset), .supply_ok(supply_ok), .bias_en(bias_en),
        .fosc_en(fosc_en), .probe_en(probe_en), .adc_ch(adc_ch), .adc_start(adc_start), .adc_done(adc_done),
        .adc_data(adc_data), .rd_ch(rd_ch), .rd_data(rd_data), .busy(busy), .low_power(low_power),
        .int_o(int_o), .int_oe(int_oe));
    hms_adc_model i_adc (.ref_clk(ref_clk), .adc_start(adc_start), .adc_ch(adc_ch), .slow(slow),
        .adc_done(adc_done), .adc_data(adc_data));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (adc_start) seq.push_back(adc_ch);

    task conclude;
        if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one master-side request pulse
    task req(input logic c, input logic t, input logic r, input logic temp);
        @(posedge ref_clk);
        cfg_wr <= c;
        trig <= t;
        if_reset <= r;
        cfg_temp_en <= temp;
        @(posedge ref_clk);
        cfg_wr <= 1'b0;
        trig <= 1'b0;
        if_reset <= 1'b0;
    endtask
    task measure(input int n);
        int k;
        for (k = 0; k < 400 && int_oe !== 1'b1; k++) @(negedge ref_clk);
        if (int_oe !== 1'b1) begin
            fails++;
            conclude;
        end
        chk("cycle length", 12'(n), 12'(seq.size()));
        for (k = 0; k < n; k++) begin
            chk("channel", 12'(k), {10'h000, seq[k]});
            @(posedge ref_clk);
            rd_ch <= k[1:0];
            @(posedge ref_clk);
            @(negedge ref_clk);
            chk("result", (k == 3) ? 12'h35A : {k[1:0], 10'h35A}, rd_data);
        end
    endtask

    task t_startup;
        int i;
        for (i = 0; i < 100 && low_power !== 1'b1; i++) @(negedge ref_clk);
        chk("low power", 12'h001, {11'h000, low_power});
        chk("busy", 12'h000, {11'h000, busy});
        if (low_power !== 1'b1) conclude;
    endtask
    task t_config;
        seq.delete();
        req(1'b1, 1'b0, 1'b0, 1'b1);
        measure(4);
    endtask
    task t_no_temp;
        seq.delete();
        req(1'b1, 1'b0, 1'b0, 1'b0);
        measure(3);
        seq.delete();
        @(posedge ref_clk) slow <= 1'b1;
        req(1'b0, 1'b1, 1'b0, 1'b0);
        measure(3);
    endtask
    task t_supply;
        int i;
        seq.delete();
        req(1'b0, 1'b1, 1'b0, 1'b0);
        for (i = 0; i < 400 && seq.size() < 2; i++) @(posedge ref_clk);
        if (seq.size() < 2) begin
            fails++;
            conclude;
        end
        supply_ok <= 1'b0;
        repeat (5) @(posedge ref_clk);
        seq.delete();
        repeat (15) @(posedge ref_clk);
        chk("starts on low supply", 12'h000, 12'(seq.size()));
        supply_ok <= 1'b1;
        measure(3);
    endtask
    task t_reset_if;
        req(1'b0, 1'b0, 1'b1, 1'b0);
        seq.delete();
        req(1'b0, 1'b1, 1'b0, 1'b0);
        clk_en <= 1'b0;
        repeat (60) @(posedge ref_clk);
        chk("frozen starts", 12'h000, 12'(seq.size()));
        chk("frozen busy", 12'h001, {11'h000, busy});
        clk_en <= 1'b1;
        measure(4);
    endtask

    initial begin
        fails = 0;
        num_checks = 0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        {cfg_wr, trig, if_reset, slow} = 4'h0;
        cfg_temp_en = 1'b1;
        supply_ok = 1'b1;
        rd_ch = 2'h0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_startup;
        t_config;
        t_no_temp;
        t_supply;
        t_reset_if;
        conclude;
    end
endmodule // hms_sequencer_test
